// File: core/crasm_pkg.sv
// register map, field positions, reset values and carrier types for the cpu/rail alert block
// assumes an smbus slave engine elsewhere turns bus transactions into single-cycle register strobes
package crasm_pkg;

  // register offsets
  localparam logic [7:0] ADDR_ALERT_STATUS   = 8'h81;
  localparam logic [7:0] ADDR_LINK_MASK      = 8'h82;
  localparam logic [7:0] ADDR_RAIL_MASK      = 8'h83;
  localparam logic [7:0] ADDR_TERM_LOW       = 8'h84;
  localparam logic [7:0] ADDR_CUR_LOW        = 8'h85;
  localparam logic [7:0] ADDR_TERM_HIGH      = 8'h86;
  localparam logic [7:0] ADDR_CUR_HIGH       = 8'h87;
  localparam logic [7:0] ADDR_TOPOLOGY       = 8'h88;

  // reset values
  localparam logic [7:0] RST_STATUS          = 8'h00;
  localparam logic [7:0] RST_MASK            = 8'h00;
  localparam logic [7:0] RST_LOW_LIMIT       = 8'h00;
  localparam logic [7:0] RST_HIGH_LIMIT      = 8'hFF;
  localparam logic [7:0] RST_TOPOLOGY        = 8'h00;

  // status and per-source mask bit positions (same layout in both)
  localparam int         BIT_CPU_TEMP_CH1    = 3;
  localparam int         BIT_CPU_TEMP_CH2    = 4;
  localparam int         BIT_CPU_TEMP_CH3    = 5;
  localparam int         BIT_CUR_MON         = 6;
  localparam int         BIT_TERM_RAIL       = 7;
  localparam logic [7:0] STATUS_IMPL_MASK    = 8'hF8;

  // link mask bit positions
  localparam int         BIT_CPU_TEMP_CH0    = 0;
  localparam int         BIT_LINK_DATA_ERR   = 1;
  localparam int         BIT_LINK_ERROR_A    = 2;
  localparam int         BIT_OVERTEMP        = 3;
  localparam int         BIT_SUMMARY_OOL     = 7;

  // topology field positions
  localparam int         BIT_CPU4_DOMAIN     = 3;
  localparam int         BIT_CPU3_DOMAIN     = 4;
  localparam int         BIT_CPU2_DOMAIN     = 5;
  localparam int         CPU_COUNT_LSB       = 6;
  localparam int         CPU_COUNT_MSB       = 7;

  // first thermal client address; one per configured cpu
  localparam logic [7:0] CLIENT_BASE_ADDR    = 8'h30;

  // one register access from the smbus engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crasm_reg_req_s;

  // one reading from a measurement engine
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } crasm_reading_s;

  // level conditions owned by other monitoring logic
  typedef struct packed {
    logic       cpu_temp_ch0_ool;
    logic       link_data_err;
    logic       link_link_error_mask_a_err;
    logic       overtemp;
    logic       other_ool;
  } crasm_ext_cond_s;

endpackage

// File: core/crasm_alert.sv
// alert status, masks, rail/current limits and cpu topology config for the cpu monitoring channels
// register strobes come from the smbus engine, readings and link conditions from the measurement engines
// the configuration lock arrives as a level from the register that owns it
// every output leaves a flip-flop; the alert pin is open-drain and only ever pulls low
`timescale 1ns/1ps

module crasm_alert #(
  parameter int DATA_W = 8                                  // register and reading width
) (
  input  wire logic                     i_clk_sys,          // system clock, 100 MHz
  input  wire logic                     i_sys_rst,          // synchronous reset, active high
  input  wire crasm_pkg::crasm_reg_req_s i_reg_req,         // register access strobe
  input  wire logic                     i_config_lock,      // configuration lock level
  input  wire logic [2:0]               i_cpu_temp_ool,     // channels 1..3 out of their limits
  input  wire crasm_pkg::crasm_reading_s i_cpu_current_monitor, // current reading
  input  wire crasm_pkg::crasm_reading_s i_termination_rail, // rail reading
  input  wire crasm_pkg::crasm_ext_cond_s i_ext_cond,       // conditions held elsewhere
  input  wire logic                     i_smbalert_in,      // alert pin level (unused by logic)
  output logic [DATA_W-1:0]             o_rd_data,          // read data
  output logic                          o_rd_valid,         // read data strobe
  output logic                          o_smbalert_out,     // alert pin drive value, always low
  output logic                          o_smbalert_oe,      // alert pin drive enable
  output logic                          o_summary_ool,      // summary out-of-limit status
  output logic [1:0]                    o_cpu_count,        // configured cpus minus one
  output logic [2:0]                    o_domain_two,       // cpus 2..4 have two domains
  output logic [7:0]                    o_last_client_addr  // highest client address polled
);

  // window check shared by both rails
  function automatic logic out_of_window(input logic [DATA_W-1:0] value,
                                         input logic [DATA_W-1:0] low,
                                         input logic [DATA_W-1:0] high);
    out_of_window = (value > high) || (value < low);
  endfunction

  // register address match, shared by every decode below
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] reg_addr);
    addr_hit = (addr == reg_addr);
  endfunction

  // cpu count field of a topology value
  function automatic logic [1:0] count_field(input logic [DATA_W-1:0] cfg);
    count_field = cfg[crasm_pkg::CPU_COUNT_MSB:crasm_pkg::CPU_COUNT_LSB];
  endfunction

  // registers
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] status_d;
  logic [DATA_W-1:0] link_mask_q;
  logic [DATA_W-1:0] link_mask_d;
  logic [DATA_W-1:0] rail_mask_q;
  logic [DATA_W-1:0] rail_mask_d;
  logic [DATA_W-1:0] term_low_q;
  logic [DATA_W-1:0] term_low_d;
  logic [DATA_W-1:0] term_high_q;
  logic [DATA_W-1:0] term_high_d;
  logic [DATA_W-1:0] cur_low_q;
  logic [DATA_W-1:0] cur_low_d;
  logic [DATA_W-1:0] cur_high_q;
  logic [DATA_W-1:0] cur_high_d;
  logic [DATA_W-1:0] topology_q;
  logic [DATA_W-1:0] topology_d;
  logic              cur_ool_q;
  logic              cur_ool_d;
  logic              term_ool_q;
  logic              term_ool_d;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic              rd_valid_q;
  logic              alert_q;
  logic              alert_d;
  logic              summary_q;
  logic              summary_d;
  logic [7:0]        last_client_q;
  logic [7:0]        last_client_d;
  logic              drive_level_q;

  // address decode
  wire logic hit_status   = addr_hit(i_reg_req.addr, crasm_pkg::ADDR_ALERT_STATUS);
  wire logic hit_link     = addr_hit(i_reg_req.addr, crasm_pkg::ADDR_LINK_MASK);
  wire logic hit_rail     = addr_hit(i_reg_req.addr, crasm_pkg::ADDR_RAIL_MASK);
  wire logic hit_term_lo  = addr_hit(i_reg_req.addr, crasm_pkg::ADDR_TERM_LOW);
  wire logic hit_cur_lo   = addr_hit(i_reg_req.addr, crasm_pkg::ADDR_CUR_LOW);
  wire logic hit_term_hi  = addr_hit(i_reg_req.addr, crasm_pkg::ADDR_TERM_HIGH);
  wire logic hit_cur_hi   = addr_hit(i_reg_req.addr, crasm_pkg::ADDR_CUR_HIGH);
  wire logic hit_topology = addr_hit(i_reg_req.addr, crasm_pkg::ADDR_TOPOLOGY);

  // protected registers take writes only while unlocked
  wire logic wr_open      = i_reg_req.wr;
  wire logic wr_locked_ok = i_reg_req.wr && !i_config_lock;

  // masks stay writable under lock; only limits and topology are protected
  wire logic we_link      = wr_open && hit_link;
  wire logic we_rail      = wr_open && hit_rail;
  wire logic we_term_lo   = wr_locked_ok && hit_term_lo;
  wire logic we_cur_lo    = wr_locked_ok && hit_cur_lo;
  wire logic we_term_hi   = wr_locked_ok && hit_term_hi;
  wire logic we_cur_hi    = wr_locked_ok && hit_cur_hi;
  wire logic we_topology  = wr_locked_ok && hit_topology;

  // cpu count gates which of the upper thermal channels can flag
  wire logic [1:0] cpu_count = count_field(topology_q);
  wire logic [2:0] chan_live = {cpu_count == 2'h3, cpu_count >= 2'h2, cpu_count >= 2'h1};

  // window comparisons, held between readings
  assign cur_ool_d  = i_cpu_current_monitor.valid
                    ? out_of_window(i_cpu_current_monitor.value, cur_low_q, cur_high_q)
                    : cur_ool_q;
  assign term_ool_d = i_termination_rail.valid
                    ? out_of_window(i_termination_rail.value, term_low_q, term_high_q)
                    : term_ool_q;

  // live condition for each status bit; reserved bits never set
  wire logic [DATA_W-1:0] cond;
  assign cond[2:0]                             = 3'h0;
  assign cond[crasm_pkg::BIT_CPU_TEMP_CH1]     = i_cpu_temp_ool[0] && chan_live[0];
  assign cond[crasm_pkg::BIT_CPU_TEMP_CH2]     = i_cpu_temp_ool[1] && chan_live[1];
  assign cond[crasm_pkg::BIT_CPU_TEMP_CH3]     = i_cpu_temp_ool[2] && chan_live[2];
  assign cond[crasm_pkg::BIT_CUR_MON]          = cur_ool_q;
  assign cond[crasm_pkg::BIT_TERM_RAIL]        = term_ool_q;

  // read-to-clear drops only bits whose condition has gone; a new event in the same cycle still sets
  wire logic              status_read = i_reg_req.rd && hit_status;
  wire logic [DATA_W-1:0] clear_mask  = status_read ? ~cond : '0;
  wire logic [DATA_W-1:0] status_kept = status_q & ~clear_mask;
  assign status_d = (status_kept | cond) & crasm_pkg::STATUS_IMPL_MASK;

  // register writes; the status register has no writable bits
  assign link_mask_d = we_link     ? i_reg_req.wdata : link_mask_q;
  assign rail_mask_d = we_rail     ? i_reg_req.wdata : rail_mask_q;
  assign term_low_d  = we_term_lo  ? i_reg_req.wdata : term_low_q;
  assign cur_low_d   = we_cur_lo   ? i_reg_req.wdata : cur_low_q;
  assign term_high_d = we_term_hi  ? i_reg_req.wdata : term_high_q;
  assign cur_high_d  = we_cur_hi   ? i_reg_req.wdata : cur_high_q;
  assign topology_d  = we_topology ? i_reg_req.wdata : topology_q;

  // read mux; status returns its value before the clear, unmapped reads return zero
  wire logic [DATA_W-1:0] rd_mux =
      hit_status   ? status_q    :
      hit_link     ? link_mask_q :
      hit_rail     ? rail_mask_q :
      hit_term_lo  ? term_low_q  :
      hit_cur_lo   ? cur_low_q   :
      hit_term_hi  ? term_high_q :
      hit_cur_hi   ? cur_high_q  :
      hit_topology ? topology_q  : '0;
  assign rd_data_d = i_reg_req.rd ? rd_mux : rd_data_q;

  // summary out-of-limit covers this block's status flags and the other_ool condition held elsewhere
  assign summary_d = (|status_q) || i_ext_cond.other_ool;

  // per-source alert paths
  wire logic [DATA_W-1:0] src_unmasked = status_q & ~rail_mask_q & crasm_pkg::STATUS_IMPL_MASK;
  wire logic ch0_alert  = i_ext_cond.cpu_temp_ch0_ool && !link_mask_q[crasm_pkg::BIT_CPU_TEMP_CH0];
  wire logic data_alert = i_ext_cond.link_data_err    && !link_mask_q[crasm_pkg::BIT_LINK_DATA_ERR];
  wire logic link_error_mask_a_alert = i_ext_cond.link_link_error_mask_a_err    && !link_mask_q[crasm_pkg::BIT_LINK_ERROR_A];
  wire logic ovt_alert  = i_ext_cond.overtemp         && !link_mask_q[crasm_pkg::BIT_OVERTEMP];

  // summary path is gated only by its own bit, so per-source masks cannot silence it
  wire logic ool_alert  = summary_q && !link_mask_q[crasm_pkg::BIT_SUMMARY_OOL];

  wire logic src_alert  = |src_unmasked;
  wire logic link_alert = ch0_alert || data_alert || link_error_mask_a_alert || ovt_alert;
  assign alert_d = ool_alert || src_alert || link_alert;

  // base has zero low bits, so or-ing the next count in equals adding it
  assign last_client_d = crasm_pkg::CLIENT_BASE_ADDR | {6'h00, count_field(topology_d)};

  // cpu_rail_alert_status, 0x81; set wins over read-clear so an event on the read is never lost
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      status_q <= crasm_pkg::RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // thermal_link_alert_mask, 0x82
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      link_mask_q <= crasm_pkg::RST_MASK;
    end else begin
      link_mask_q <= link_mask_d;
    end
  end

  // cpu_rail_alert_mask, 0x83
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rail_mask_q <= crasm_pkg::RST_MASK;
    end else begin
      rail_mask_q <= rail_mask_d;
    end
  end

  // term_rail_low_limit, 0x84
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      term_low_q <= crasm_pkg::RST_LOW_LIMIT;
    end else begin
      term_low_q <= term_low_d;
    end
  end

  // cpu_current_low_limit, 0x85
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cur_low_q <= crasm_pkg::RST_LOW_LIMIT;
    end else begin
      cur_low_q <= cur_low_d;
    end
  end

  // term_rail_high_limit, 0x86
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      term_high_q <= crasm_pkg::RST_HIGH_LIMIT;
    end else begin
      term_high_q <= term_high_d;
    end
  end

  // cpu_current_high_limit, 0x87
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cur_high_q <= crasm_pkg::RST_HIGH_LIMIT;
    end else begin
      cur_high_q <= cur_high_d;
    end
  end

  // cpu_topology_config, 0x88
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      topology_q <= crasm_pkg::RST_TOPOLOGY;
    end else begin
      topology_q <= topology_d;
    end
  end

  // window flags keep the verdict of the last valid reading
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cur_ool_q <= 1'b0;
    end else begin
      cur_ool_q <= cur_ool_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      term_ool_q <= 1'b0;
    end else begin
      term_ool_q <= term_ool_d;
    end
  end

  // read port: data holds until the next read, the strobe lasts one cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= i_reg_req.rd;
    end
  end

  // alert enable and summary level
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= alert_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= summary_d;
    end
  end

  // the count resets to one cpu, so the last client resets to the base address
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      last_client_q <= crasm_pkg::CLIENT_BASE_ADDR;
    end else begin
      last_client_q <= last_client_d;
    end
  end

  // open-drain drive value kept in a flop like every other output; it never leaves low
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      drive_level_q <= 1'b0;
    end else begin
      drive_level_q <= 1'b0;
    end
  end

  // outputs; only the enable of the open-drain pin moves
  assign o_smbalert_out = drive_level_q;
  assign o_smbalert_oe  = alert_q;
  assign o_rd_data      = rd_data_q;
  assign o_rd_valid     = rd_valid_q;
  assign o_summary_ool  = summary_q;

  // count and domain outputs straight from the config register; last client address from its own flop
  assign o_cpu_count  = topology_q[crasm_pkg::CPU_COUNT_MSB:crasm_pkg::CPU_COUNT_LSB];
  assign o_domain_two = {topology_q[crasm_pkg::BIT_CPU4_DOMAIN],
                         topology_q[crasm_pkg::BIT_CPU3_DOMAIN],
                         topology_q[crasm_pkg::BIT_CPU2_DOMAIN]};
  assign o_last_client_addr = last_client_q;

endmodule

// File: bench/crasm_alert_properties.sv
// port assertions for the cpu/rail alert block
// bound to crasm_alert from the bench top; one clock, synchronous reset
`timescale 1ns/1ps
module crasm_alert_checker #(
  parameter int DATA_W = 8                              // read data width
) (
  input wire logic                       i_clk_sys,     // clock
  input wire logic                       i_sys_rst,     // reset
  input wire crasm_pkg::crasm_reg_req_s  i_reg_req,     // register strobe
  input wire logic                       i_config_lock, // lock level
  input wire logic [2:0]                 i_cpu_temp_ool, // channels 1..3 out
  input wire crasm_pkg::crasm_ext_cond_s i_ext_cond,    // outside conditions
  input wire logic [DATA_W-1:0]          o_rd_data,     // read data
  input wire logic                       o_rd_valid,    // read strobe
  input wire logic                       o_smbalert_out, // pin value
  input wire logic                       o_summary_ool, // summary level
  input wire logic [1:0]                 o_cpu_count,   // cpu count
  input wire logic [2:0]                 o_domain_two,  // two-domain flags
  input wire logic [7:0]                 o_last_client_addr // last client
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  wire logic topo_wr = i_reg_req.wr && i_reg_req.addr == crasm_pkg::ADDR_TOPOLOGY;

  a_read_answer: assert property (i_reg_req.rd |=> o_rd_valid)
    else $error("read not answered");
  a_reserved_zero: assert property (i_reg_req.rd && i_reg_req.addr == crasm_pkg::ADDR_ALERT_STATUS |=> o_rd_data[2:0] == 3'h0)
    else $error("reserved status bits set");
  a_pin_low: assert property (o_smbalert_out == 1'b0)
    else $error("alert pin value high");
  a_client_addr: assert property (o_last_client_addr == crasm_pkg::CLIENT_BASE_ADDR + {6'h00, o_cpu_count})
    else $error("client address off");
  a_lock_holds: assert property (i_config_lock && topo_wr |=> $stable(o_cpu_count) && $stable(o_domain_two))
    else $error("locked topology changed");
  a_topo_take: assert property (!i_config_lock && topo_wr |=> o_cpu_count == $past(i_reg_req.wdata[7:6]) &&
    o_domain_two == {$past(i_reg_req.wdata[3]), $past(i_reg_req.wdata[4]), $past(i_reg_req.wdata[5])})
    else $error("topology write lost");
  a_other_summary: assert property (i_ext_cond.other_ool |=> o_summary_ool)
    else $error("summary missed");
  a_ch1_summary: assert property ((i_cpu_temp_ool[0] && o_cpu_count != 2'h0) [*2] |=> o_summary_ool)
    else $error("channel 1 not flagged");
endmodule

// File: bench/crasm_host_model.sv
// smbus host stand-in: turns register reads and writes into single-cycle strobes
// assumes the block takes a strobe on the rising edge and answers reads one cycle later
`timescale 1ns/1ps
module crasm_host_model (
  input  wire logic                 i_clk_sys,  // system clock
  input  wire logic [7:0]           i_rd_data,  // read data
  input  wire logic                 i_rd_valid, // read data strobe
  output crasm_pkg::crasm_reg_req_s o_req       // register strobe
);
  initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
  // released fields show the inverse so a stale address never looks live
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge i_clk_sys);
    #1;
    o_req = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(posedge i_clk_sys);
    #1;
    rdata = i_rd_valid ? i_rd_data : 8'hXX;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask
endmodule

// File: bench/crasm_alert_tb_top.sv
// self-checking bench for crasm_alert; registers through the host model, readings driven here
// assumes status and alert levels settle within three cycles of their cause
`timescale 1ns/1ps
module crasm_alert_tb_top;
  logic                       clk_sys;
  logic                       sys_rst;
  logic                       lock;
  logic [2:0]                 summary_out_of_limit;
  crasm_pkg::crasm_reg_req_s  req;
  crasm_pkg::crasm_reading_s  cur;
  crasm_pkg::crasm_reading_s  rail;
  crasm_pkg::crasm_ext_cond_s ext;
  logic [7:0]                 rdat;
  logic [7:0]                 last;
  logic                       rval;
  logic                       a_out;
  logic                       a_oe;
  logic                       summ;
  logic [1:0]                 cnt;
  logic [2:0]                 dom;
  logic                       pin;
  int                         bad_count;
  int                         n_tests;
  int                         cycles = 0;
  assign pin = a_oe ? a_out : 1'b1;
  crasm_alert i_crasm_alert (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_reg_req(req), .i_config_lock(lock),
    .i_cpu_temp_ool(summary_out_of_limit), .i_cpu_current_monitor(cur), .i_termination_rail(rail), .i_ext_cond(ext),
    .i_smbalert_in(pin), .o_rd_data(rdat), .o_rd_valid(rval), .o_smbalert_out(a_out), .o_smbalert_oe(a_oe),
    .o_summary_ool(summ), .o_cpu_count(cnt), .o_domain_two(dom), .o_last_client_addr(last));
  crasm_host_model i_crasm_host_model (.i_clk_sys(clk_sys), .i_rd_data(rdat), .i_rd_valid(rval), .o_req(req));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic test_done;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("MISMATCH %0t timeout", $time);
      test_done();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] t;
    i_crasm_host_model.access(1'b1, a, d, t);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_crasm_host_model.access(1'b0, a, 8'h00, d);
  endtask
  task automatic pulse(input logic [7:0] v);
    cur = '{valid: 1'b1, value: v};
    rail = '{valid: 1'b1, value: v};
    cyc(1);
    cur = '{valid: 1'b0, value: ~v};
    rail = '{valid: 1'b0, value: ~v};
  endtask
  task automatic t_reset_topology;
    logic [7:0] v;
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      rd(8'h81 + 8'(i), v);
      check(v, (i == 5 || i == 6) ? 8'hFF : 8'h00, "reset");
    end
    check({7'h00, a_oe}, 8'h00, "idle alert");
    wr(8'h81, 8'hFF);
    rd(8'h81, v);
    check(v, 8'h00, "status write");
    for (int c = 0; c < 4; c++) begin
      d = {c[1:0], 3'(c + 1), 3'h7};
      wr(8'h88, d);
      rd(8'h88, v);
      check(v, d, "topology");
      check({cnt, dom, 3'h0}, {d[7:6], d[3], d[4], d[5], 3'h0}, "count/domains");
      check(last, 8'h30 + {6'h00, d[7:6]}, "client");
    end
    $display("reset and topology done");
  endtask
  task automatic t_thermal;
    logic [7:0] v;
    wr(8'h88, 8'hC0);
    summary_out_of_limit = 3'h7;
    cyc(2);
    rd(8'h81, v);
    check(v, 8'h38, "channels");
    summary_out_of_limit = 3'h2;
    rd(8'h81, v);
    check(v, 8'h38, "kept");
    rd(8'h81, v);
    check(v, 8'h10, "partial clear");
    wr(8'h88, 8'h40);
    summary_out_of_limit = 3'h7;
    cyc(2);
    rd(8'h81, v);
    rd(8'h81, v);
    check(v, 8'h08, "count gating");
    wr(8'h88, 8'h80);
    rd(8'h81, v);
    rd(8'h81, v);
    check(v, 8'h18, "three cpus");
    wr(8'h88, 8'h00);
    rd(8'h81, v);
    rd(8'h81, v);
    check(v, 8'h00, "one cpu");
    summary_out_of_limit = 3'h0;
    rd(8'h81, v);
    rd(8'h81, v);
    check(v, 8'h00, "cleared");
    wr(8'h88, 8'hC0);
    $display("thermal done");
  endtask
  task automatic t_window;
    logic [7:0] v;
    logic [7:0] vals [8] = '{8'h91, 8'h90, 8'h20, 8'h1F, 8'h3F, 8'h40, 8'hC0, 8'hC1};
    wr(8'h84, 8'h40);
    wr(8'h85, 8'h20);
    wr(8'h86, 8'hC0);
    wr(8'h87, 8'h90);
    foreach (vals[i]) begin
      pulse(vals[i]);
      cyc(3);
      rd(8'h81, v);
      rd(8'h81, v);
      check(v, {vals[i] > 8'hC0 || vals[i] < 8'h40, vals[i] > 8'h90 || vals[i] < 8'h20, 6'h00}, "window");
    end
    $display("window done");
  endtask
  task automatic t_masks;
    logic [7:0] v;
    check({7'h00, a_oe}, 8'h01, "source alert");
    wr(8'h83, 8'hF8);
    cyc(3);
    check({7'h00, a_oe}, 8'h01, "summary path");
    wr(8'h82, 8'h80);
    cyc(3);
    check({7'h00, a_oe}, 8'h00, "all masked");
    wr(8'h83, 8'h07);
    cyc(3);
    check({7'h00, a_oe}, 8'h01, "source unmasked");
    wr(8'h83, 8'hF8);
    pulse(8'h80);
    cyc(3);
    rd(8'h81, v);
    rd(8'h81, v);
    for (int i = 0; i < 4; i++) begin
      ext = crasm_pkg::crasm_ext_cond_s'({4'(8'h08 >> i), 1'b0});
      cyc(3);
      check({7'h00, a_oe}, 8'h01, "link alert");
      wr(8'h82, 8'h80 | (8'h01 << i));
      cyc(3);
      check({7'h00, a_oe}, 8'h00, "link masked");
      ext = '0;
      wr(8'h82, 8'h80);
    end
    wr(8'h82, 8'h00);
    ext.other_ool = 1'b1;
    cyc(3);
    check({6'h00, summ, a_oe}, 8'h03, "summary alert");
    wr(8'h82, 8'h80);
    cyc(3);
    check({7'h00, a_oe}, 8'h00, "summary masked");
    ext = '0;
    $display("masks done");
  endtask
  task automatic t_lock;
    logic [7:0] v;
    logic [7:0] keep [5] = '{8'h40, 8'h20, 8'hC0, 8'h90, 8'hC0};
    lock = 1'b1;
    foreach (keep[i]) begin
      wr(8'h84 + 8'(i), 8'h5A);
      rd(8'h84 + 8'(i), v);
      check(v, keep[i], "locked");
    end
    lock = 1'b0;
    wr(8'h84, 8'h5A);
    rd(8'h84, v);
    check(v, 8'h5A, "unlocked");
    $display("lock done");
  endtask
  initial begin
    sys_rst = 1'b1;
    lock = 1'b0;
    summary_out_of_limit = 3'h0;
    cur = '0;
    rail = '0;
    ext = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    t_reset_topology();
    t_thermal();
    t_window();
    t_masks();
    t_lock();
    test_done();
  end
endmodule

bind crasm_alert crasm_alert_checker #(.DATA_W(DATA_W)) i_crasm_alert_checker (.i_clk_sys(i_clk_sys),
  .i_sys_rst(i_sys_rst), .i_reg_req(i_reg_req), .i_config_lock(i_config_lock), .i_cpu_temp_ool(i_cpu_temp_ool),
  .i_ext_cond(i_ext_cond), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_smbalert_out(o_smbalert_out),
  .o_summary_ool(o_summary_ool), .o_cpu_count(o_cpu_count), .o_domain_two(o_domain_two),
  .o_last_client_addr(o_last_client_addr));
